// >>> bcr_boot_regs.sv
// boot strap capture and boot completion register bank
//
// Behaviour
// - strap capture register ignores every write
// - each strap field holds pin level caught at reset release
// - bit 20 reports byte order, 0 big, 1 little endian
// - bit 19 reports fast start strap
// - bits 14:12 hold multiplier select straps, used only with fast start
// - bits 10:8 hold pinout straps, give pin-mux pinout field default
// - bits 3:0 hold boot source straps, forming boot mode with others
// - reserved strap register bits ignore writes, read fixed values
// - completion register bits 19:16 hold error code, zero default
// - nonzero error code means boot aborted by firmware
// - done flag set with zero error code makes processor jump to start address
// - global reset clears whole completion register
// - done flag defaults zero, meaningful only for host-port boot; cpuJump still follows it in every boot mode
// - host-port boot selectable with and without fast start
// - host-port boot defaults start to boot ROM, releases cpu at once
`timescale 1ns/1ps
module bcr_boot_regs #(
    parameter logic [3:0] HOST_BOOT_CODE = 4'h0
) (
    // clock and global reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // strap pins
    input  wire logic        strapByteOrder,
    input  wire logic        strapFastStart,
    input  wire logic [2:0]  strapMultSel,
    input  wire logic [2:0]  strapPinout,
    input  wire logic [3:0]  strapBootSrc,
    // register port
    input  wire logic [31:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    // start address register contents
    input  wire logic [31:0] cpuStartAddress,
    // configuration results
    output logic             byteOrderSelect,
    output logic             fastStart,
    output logic      [2:0]  multiplierSelect,
    output logic      [2:0]  defaultPinoutSelect,
    output logic      [3:0]  bootSource,
    output logic             hostPortBoot,
    output logic             cpuRelease,
    output logic      [31:0] defaultStartAddr,
    // completion results
    output logic             hostDoneFlag,
    output logic             bootError,
    output logic             cpuJump,
    output logic      [31:0] cpuJumpAddr
);

    // ==========================================================
    // strap capture
    logic        captured_reg;
    logic [31:0] strapWord_reg;
    logic [31:0] strapWord_next;
    wire  [3:0]  bootSrcNow = strapWord_reg[bcr_pkg::BOOT_SRC_LSB +: bcr_pkg::BOOT_SRC_W];
    // fast start ignored in host-port decode
    wire         hostSel    = (bootSrcNow == HOST_BOOT_CODE);

    always_comb begin
        strapWord_next = bcr_pkg::ZERO_WORD;
        strapWord_next[bcr_pkg::RSV_HI_LSB +: $bits(bcr_pkg::RSV_HI_VAL)] = bcr_pkg::RSV_HI_VAL;
        strapWord_next[bcr_pkg::BYTE_ORDER_BIT] = strapByteOrder;
        strapWord_next[bcr_pkg::FAST_START_BIT] = strapFastStart;
        strapWord_next[bcr_pkg::MULT_LSB +: bcr_pkg::MULT_W] = strapMultSel;
        strapWord_next[bcr_pkg::PINOUT_LSB +: bcr_pkg::PINOUT_W] = strapPinout;
        strapWord_next[bcr_pkg::BOOT_SRC_LSB +: bcr_pkg::BOOT_SRC_W] = strapBootSrc;
    end

    // caught on first edge after release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            captured_reg <= 1'b0;
        end else begin
            captured_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            strapWord_reg <= bcr_pkg::ZERO_WORD;
        end else if (!captured_reg) begin
            strapWord_reg <= strapWord_next;
        end
    end

    // ==========================================================
    // completion register
    wire hitCompl = (regAddr == bcr_pkg::COMPLETION_ADDR);
    wire hitStrap = (regAddr == bcr_pkg::STRAP_ADDR);
    wire wrCompl  = regWrite && hitCompl;

    logic [3:0] err_reg;
    logic       done_reg;

    // global reset clears error and flag
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            err_reg  <= bcr_pkg::ERR_NONE;
            done_reg <= 1'b0;
        end else if (wrCompl) begin
            err_reg  <= regWdata[bcr_pkg::ERR_LSB +: bcr_pkg::ERR_W];
            done_reg <= regWdata[bcr_pkg::DONE_BIT];
        end
    end

    wire [31:0] complWord = {12'h000, err_reg, 15'h0000, done_reg};

    // ==========================================================
    // read path, unmapped reads return zero
    // strap register has no write path
    wire [31:0] rdSel = hitStrap ? strapWord_reg :
                        hitCompl ? complWord : bcr_pkg::ZERO_WORD;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= bcr_pkg::ZERO_WORD;
        end else if (regRead) begin
            regRdata <= rdSel;
        end
    end

    // ==========================================================
    // configuration outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            byteOrderSelect     <= 1'b0;
            fastStart           <= 1'b0;
            multiplierSelect    <= 3'h0;
            defaultPinoutSelect <= 3'h0;
            bootSource          <= 4'h0;
            hostPortBoot        <= 1'b0;
            cpuRelease          <= 1'b0;
            defaultStartAddr    <= bcr_pkg::ZERO_WORD;
        end else begin
            byteOrderSelect     <= strapWord_reg[bcr_pkg::BYTE_ORDER_BIT];
            fastStart           <= strapWord_reg[bcr_pkg::FAST_START_BIT];
            multiplierSelect    <= strapWord_reg[bcr_pkg::MULT_LSB +: bcr_pkg::MULT_W];
            defaultPinoutSelect <= strapWord_reg[bcr_pkg::PINOUT_LSB +: bcr_pkg::PINOUT_W];
            bootSource          <= bootSrcNow;
            hostPortBoot        <= captured_reg && hostSel;
            // host boot releases cpu into boot rom
            cpuRelease          <= captured_reg && hostSel;
            defaultStartAddr    <= bcr_pkg::ROM_START_ADDR;
        end
    end

    // ==========================================================
    // completion outputs and jump request
    logic doneSeen_reg;
    // jump on rising done flag without error
    wire  jumpNow = done_reg && !doneSeen_reg && (err_reg == bcr_pkg::ERR_NONE);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            doneSeen_reg <= 1'b0;
            hostDoneFlag <= 1'b0;
            bootError    <= 1'b0;
            cpuJump      <= 1'b0;
            cpuJumpAddr  <= bcr_pkg::ZERO_WORD;
        end else begin
            doneSeen_reg <= done_reg;
            // flag only reported in host-port boot
            hostDoneFlag <= done_reg && hostPortBoot;
            // nonzero code flags an aborted boot
            bootError    <= (err_reg != bcr_pkg::ERR_NONE);
            cpuJump      <= jumpNow;
            if (jumpNow) begin
                cpuJumpAddr <= cpuStartAddress & bcr_pkg::LOW_IGNORE_MASK;
            end
        end
    end

    // ==========================================================
    // checks
    property p_strap_stable;
        @(posedge ref_clk) disable iff (!rstn)
        captured_reg && $past(captured_reg) |-> $stable(strapWord_reg);
    endproperty
    a_strap_stable: assert property (p_strap_stable)
        else $error("strap word changed after capture");

    property p_strap_capture;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(captured_reg) |->
            strapWord_reg[bcr_pkg::BOOT_SRC_LSB +: 4] == $past(strapBootSrc) &&
            strapWord_reg[bcr_pkg::BYTE_ORDER_BIT] == $past(strapByteOrder);
    endproperty
    a_strap_capture: assert property (p_strap_capture)
        else $error("strap field does not match pins at release");

    property p_strap_ro;
        @(posedge ref_clk) disable iff (!rstn)
        regWrite && hitStrap && captured_reg |=> $stable(strapWord_reg);
    endproperty
    a_strap_ro: assert property (p_strap_ro)
        else $error("write changed strap register");

    property p_reserved;
        @(posedge ref_clk) disable iff (!rstn)
        regRead && hitStrap && captured_reg |=>
            regRdata[31:21] == bcr_pkg::RSV_HI_VAL && regRdata[18:15] == 4'h0 &&
            regRdata[11] == 1'b0 && regRdata[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved strap bits read wrong");

    property p_err_write;
        @(posedge ref_clk) disable iff (!rstn)
        wrCompl |=> err_reg == $past(regWdata[19:16]) ##1 bootError == ($past(err_reg) != 4'h0);
    endproperty
    a_err_write: assert property (p_err_write)
        else $error("error field not written or reported");

    property p_jump;
        @(posedge ref_clk) disable iff (!rstn)
        wrCompl && regWdata[0] && !done_reg && regWdata[19:16] == 4'h0 |=> ##1 cpuJump;
    endproperty
    a_jump: assert property (p_jump)
        else $error("no jump after done flag");

    property p_jump_err;
        @(posedge ref_clk) disable iff (!rstn)
        cpuJump |-> $past(err_reg) == 4'h0 && cpuJumpAddr[9:0] == 10'h000;
    endproperty
    a_jump_err: assert property (p_jump_err)
        else $error("jump despite error or low bits set");

    property p_host_release;
        @(posedge ref_clk) disable iff (!rstn)
        captured_reg && hostSel |=> cpuRelease && defaultStartAddr == bcr_pkg::ROM_START_ADDR;
    endproperty
    a_host_release: assert property (p_host_release)
        else $error("host boot not released into rom");

endmodule : bcr_boot_regs

// >>> bcr_host_model.sv
// host-side model: start-address register and register port master
`timescale 1ns/1ps
module bcr_host_model (
    // clock
    input  wire logic        ref_clk,
    // register port master
    output logic      [31:0] regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic      [31:0] regWdata,
    input  wire logic [31:0] regRdata,
    // start address register contents
    output logic      [31:0] cpuStartAddress
);
    initial begin
        regAddr = bcr_pkg::ZERO_WORD;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = bcr_pkg::ZERO_WORD;
        cpuStartAddress = bcr_pkg::ROM_START_ADDR;
    end

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        regAddr <= addr;
        regWrite <= 1'b1;
        regWdata <= (addr === bcr_pkg::COMPLETION_ADDR) ? (data & 32'h000f0001) : data;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regWdata <= ~regWdata;
    endtask : wr

    task automatic rd(input logic [31:0] addr, output logic [31:0] data);
        @(posedge ref_clk);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        data = regRdata;
    endtask : rd

    task automatic host_boot(input logic [31:0] addr);
        @(posedge ref_clk);
        // start address first, low bits zero
        cpuStartAddress <= addr & bcr_pkg::LOW_IGNORE_MASK;
        wr(bcr_pkg::COMPLETION_ADDR, 32'h00000001);
    endtask : host_boot
endmodule : bcr_host_model

// >>> bcr_pkg.sv
// constants for the boot configuration and completion registers
package bcr_pkg;
    // register byte addresses
    localparam logic [31:0] COMPLETION_ADDR  = 32'h01c4000c;
    localparam logic [31:0] STRAP_ADDR       = 32'h01c40014;
    // strap capture field positions
    localparam int          BYTE_ORDER_BIT   = 20;
    localparam int          FAST_START_BIT   = 19;
    localparam int          MULT_LSB         = 12;
    localparam int          PINOUT_LSB       = 8;
    localparam int          BOOT_SRC_LSB     = 0;
    localparam int          MULT_W           = 3;
    localparam int          PINOUT_W         = 3;
    localparam int          BOOT_SRC_W       = 4;
    // reserved fixed read value of bits 31:21
    localparam int          RSV_HI_LSB       = 21;
    localparam logic [10:0] RSV_HI_VAL       = 11'h001;
    // completion register fields
    localparam int          ERR_LSB          = 16;
    localparam int          ERR_W            = 4;
    localparam int          DONE_BIT         = 0;
    localparam logic [3:0]  ERR_NONE         = 4'h0;
    // start addresses
    localparam logic [31:0] ROM_START_ADDR   = 32'h00100000;
    localparam logic [31:0] LOW_IGNORE_MASK  = 32'hfffffc00;
    localparam logic [31:0] ZERO_WORD        = 32'h00000000;
endpackage : bcr_pkg

// >>> testbench.sv
// self-checking bench for the boot register bank
`timescale 1ns/1ps
module testbench;
    logic        ref_clk;
    logic        rstn;
    logic        strapByteOrder, strapFastStart;
    logic [2:0]  strapMultSel, strapPinout;
    logic [3:0]  strapBootSrc;
    wire  [31:0] regAddr, regWdata, regRdata, cpuStartAddress, defaultStartAddr, cpuJumpAddr;
    wire         regWrite, regRead, byteOrderSelect, fastStart, hostPortBoot, cpuRelease;
    wire         hostDoneFlag, bootError, cpuJump;
    wire  [2:0]  multiplierSelect, defaultPinoutSelect;
    wire  [3:0]  bootSource;
    int          failCount;
    int          numChecks;
    logic [31:0] rdat;
    logic        host, seen;
    // strap sets: order, fast start, multiplier, pinout, boot source
    logic [11:0] cfg [3] = '{12'hea0, 12'h1d0, 12'hb17};

    bcr_boot_regs u_dut (
        .ref_clk, .rstn, .strapByteOrder, .strapFastStart, .strapMultSel, .strapPinout,
        .strapBootSrc, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .cpuStartAddress,
        .byteOrderSelect, .fastStart, .multiplierSelect, .defaultPinoutSelect, .bootSource,
        .hostPortBoot, .cpuRelease, .defaultStartAddr, .hostDoneFlag, .bootError, .cpuJump,
        .cpuJumpAddr
    );
    bcr_host_model u_host (
        .ref_clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .cpuStartAddress
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] exp_strap(input logic [11:0] c);
        return {11'h001, c[11], c[10], 4'h0, c[9:7], 1'b0, c[6:4], 4'h0, c[3:0]};
    endfunction : exp_strap

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrapUp;
        if (failCount == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrapUp

    task automatic reset_dut(input logic [11:0] c);
        @(posedge ref_clk);
        rstn <= 1'b0;
        {strapByteOrder, strapFastStart, strapMultSel, strapPinout, strapBootSrc} <= c;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : reset_dut

    initial begin
        rstn = 1'b0;
        {strapByteOrder, strapFastStart, strapMultSel, strapPinout, strapBootSrc} = cfg[0];
        failCount = 0;
        numChecks = 0;
        for (int i = 0; i < 3; i++) begin
            host = (cfg[i][3:0] == 4'h0);
            reset_dut(cfg[i]);
            u_host.rd(bcr_pkg::STRAP_ADDR, rdat);
            chk("strap word", exp_strap(cfg[i]), rdat);
            chk("strap outputs", {20'h0, cfg[i]}, {20'h0, byteOrderSelect, fastStart,
                multiplierSelect, defaultPinoutSelect, bootSource});
            chk("release", {30'h0, host, host},
                {30'h0, hostPortBoot, cpuRelease});
            chk("default start", bcr_pkg::ROM_START_ADDR, defaultStartAddr);
            u_host.rd(bcr_pkg::COMPLETION_ADDR, rdat);
            chk("completion reset", bcr_pkg::ZERO_WORD, rdat);
            u_host.wr(bcr_pkg::STRAP_ADDR, 32'hffffffff);
            @(posedge ref_clk);
            {strapByteOrder, strapFastStart, strapMultSel, strapPinout, strapBootSrc} <= ~cfg[i];
            u_host.rd(bcr_pkg::STRAP_ADDR, rdat);
            chk("strap after write", exp_strap(cfg[i]), rdat);
            u_host.rd(32'h01c40010, rdat);
            chk("unmapped read", bcr_pkg::ZERO_WORD, rdat);
            u_host.host_boot(32'h80001000);
            seen = 1'b0;
            for (int k = 0; k < 6 && seen !== 1'b1; k++) begin
                @(posedge ref_clk);
                #1;
                seen = cpuJump;
            end
            if (host) begin
                chk("jump", 32'h1, {31'h0, seen});
                chk("jump address", 32'h80001000, cpuJumpAddr);
            end
            chk("done flag", {31'h0, host}, {31'h0, hostDoneFlag});
            u_host.rd(bcr_pkg::COMPLETION_ADDR, rdat);
            chk("completion done", 32'h1, rdat);
            u_host.wr(bcr_pkg::COMPLETION_ADDR, 32'h00030000);
            repeat (2) @(posedge ref_clk);
            #1;
            chk("boot error", 32'h1, {31'h0, bootError});
            u_host.rd(bcr_pkg::COMPLETION_ADDR, rdat);
            chk("error code", 32'h00030000, rdat);
            // done rising while an error code stands must not start the cpu
            u_host.wr(bcr_pkg::COMPLETION_ADDR, 32'h00030001);
            seen = 1'b0;
            repeat (4) begin
                @(posedge ref_clk);
                #1;
                seen = seen | cpuJump;
            end
            chk("jump despite error", 32'h0, {31'h0, seen});
            u_host.rd(bcr_pkg::COMPLETION_ADDR, rdat);
            chk("error and done", 32'h00030001, rdat);
        end
        wrapUp();
    end
endmodule : testbench
